//--- core/asq_pkg.sv
/*
  Shared constants and types of the analyzer sample access sequencer:
  register offsets, field positions, reset values, state and activity codes.
  Assumes a single 100 MHz clock domain and a word-indexed register port.
*/
package asq_pkg;
  localparam int CH_NUM   = 2;
  localparam int DIN_NUM  = 2;
  localparam int DOUT_NUM = 2;
  localparam int AW       = 4;
  localparam int DW       = 32;
  localparam int TW       = 16;

  localparam logic [AW-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [AW-1:0] ADDR_CMD    = 4'h1;
  localparam logic [AW-1:0] ADDR_LEAD   = 4'h2;
  localparam logic [AW-1:0] ADDR_SREQ   = 4'h3;
  localparam logic [AW-1:0] ADDR_MEAS   = 4'h4;
  localparam logic [AW-1:0] ADDR_CAL    = 4'h5;
  localparam logic [AW-1:0] ADDR_CLEAN  = 4'h6;
  localparam logic [AW-1:0] ADDR_OUTSEL = 4'h7;
  localparam logic [AW-1:0] ADDR_STATUS = 4'h8;

  localparam int CMD_STRIDE = 3;

  localparam logic [7:0]    CTRL_RST   = 8'hD9;
  localparam logic [TW-1:0] LEAD_RST   = 16'h0064;
  localparam logic [TW-1:0] SREQ_RST   = 16'h00C8;
  localparam logic [TW-1:0] MEAS_RST   = 16'h03E8;
  localparam logic [TW-1:0] CAL_RST    = 16'h07D0;
  localparam logic [TW-1:0] CLEAN_RST  = 16'h01F4;
  localparam logic [3:0]    OUTSEL_RST = 4'h8;

  localparam logic [1:0] SEL_MEAS_CH1 = 2'h0;
  localparam logic [1:0] SEL_MEAS_CH2 = 2'h1;
  localparam logic [1:0] SEL_SREQ_CH1 = 2'h2;
  localparam logic [1:0] SEL_SREQ_CH2 = 2'h3;

  typedef struct packed {
    logic       trig_pol;
    logic [1:0] in_sel;
    logic [1:0] in_pol;
    logic [1:0] cont;
    logic       dual;
  } asq_cfg_t;

  typedef enum logic [2:0] {
    ASQ_IDLE = 3'h1,
    ASQ_LEAD = 3'h2,
    ASQ_RUN  = 3'h4
  } asq_state_t;

  typedef enum logic [2:0] {
    ASQ_K_MEAS  = 3'h1,
    ASQ_K_CAL   = 3'h2,
    ASQ_K_CLEAN = 3'h4
  } asq_kind_t;
endpackage

//--- core/asq_sequencer.sv
/*
  Analyzer sample access sequencer: per-channel scheduling of measurement,
  calibration and cleaning under a process-access input, sample-request lead
  time, selectable binary outputs and cleaning-master forwarding.
  Assumes a plain register port on the same clock and asynchronous binary pins.
*/
`timescale 1ns/1ps

// Function
// - External cleaning trigger drives the master's own cleaning unit output.
// - Cleaning trigger is forwarded as hold to devices without cleaning units.
// - Cleaning trigger is forwarded to self-cleaning remote points simultaneously.
// - Activities start only while the channel's process-access input is active.
// - Pending activities wait while access is inactive, then follow the schedule.
// - Measurement-active is high only during measurements, never calibration or cleaning.
// - Sample-required rises for a configurable time before every activity.
// - Continuous mode starts a measurement as soon as access becomes active.
// - Due calibration or cleaning runs first, measurement follows after another lead time.
// - Continuous mode chains measurements, each after a new lead time, while access stays active.
// - Each binary input has a configurable active polarity, high or low.
// - Each channel picks its own access input; single-channel offers channel one only.
// - Binary outputs show a selected channel's state; channel two only if dual.
// - Activity start is delayed by the lead time plus one cycle after sample-required rises.
// - Sample-required output is high while sample is required, low otherwise.
module asq_sequencer
  import asq_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_in,
  input  wire logic                arst_n_in,
  // Register port
  input  wire logic [AW-1:0]       reg_addr_in,
  input  wire logic [DW-1:0]       reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [DW-1:0]       reg_rdata_out,
  // Binary inputs
  input  wire logic [DIN_NUM-1:0]  bin_in,
  input  wire logic                clean_trig_in,
  // Analyzer outputs
  output logic      [CH_NUM-1:0]   meas_active_out,
  output logic      [CH_NUM-1:0]   sample_req_out,
  output logic      [DOUT_NUM-1:0] bin_out,
  // Cleaning master outputs
  output logic                     clean_unit_out,
  output logic                     hold_fwd_out,
  output logic                     clean_fwd_out
);

  asq_cfg_t          cfg;
  asq_cfg_t          next_cfg;
  logic [TW-1:0]     lead_time;
  logic [TW-1:0]     next_lead_time;
  logic [TW-1:0]     sreq_time;
  logic [TW-1:0]     next_sreq_time;
  logic [TW-1:0]     meas_time;
  logic [TW-1:0]     next_meas_time;
  logic [TW-1:0]     cal_time;
  logic [TW-1:0]     next_cal_time;
  logic [TW-1:0]     clean_time;
  logic [TW-1:0]     next_clean_time;
  logic [3:0]        outsel;
  logic [3:0]        next_outsel;
  logic [DW-1:0]     next_rdata;
  logic [DIN_NUM:0]  sync1;
  logic [DIN_NUM:0]  sync2;
  logic [DIN_NUM-1:0] din_act;
  logic              trig_act;
  logic [CH_NUM-1:0] access;
  wire  [CH_NUM-1:0] meas_nx;
  wire  [CH_NUM-1:0] sreq_nx;
  wire  [CH_NUM-1:0] clean_nx;
  wire  [8:0]        ch_status [CH_NUM];
  logic [DOUT_NUM-1:0] next_bin;

  // The first stage feeds only the second; nothing else samples it.
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {clean_trig_in, bin_in};
      sync2 <= sync1;
    end
  end

  always_comb begin
    din_act  = sync2[DIN_NUM-1:0] ~^ cfg.in_pol;
    trig_act = sync2[DIN_NUM] ~^ cfg.trig_pol;
    access[0] = din_act[cfg.in_sel[0]];
    // Channel two is inert on a single-channel build.
    access[1] = cfg.dual & din_act[cfg.in_sel[1]];
  end

  always_comb begin
    next_cfg        = cfg;
    next_lead_time  = lead_time;
    next_sreq_time  = sreq_time;
    next_meas_time  = meas_time;
    next_cal_time   = cal_time;
    next_clean_time = clean_time;
    next_outsel     = outsel;
    next_rdata      = '0;
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_CTRL:   next_cfg        = asq_cfg_t'(reg_wdata_in[7:0]);
        ADDR_LEAD:   next_lead_time  = reg_wdata_in[TW-1:0];
        ADDR_SREQ:   next_sreq_time  = reg_wdata_in[TW-1:0];
        ADDR_MEAS:   next_meas_time  = reg_wdata_in[TW-1:0];
        ADDR_CAL:    next_cal_time   = reg_wdata_in[TW-1:0];
        ADDR_CLEAN:  next_clean_time = reg_wdata_in[TW-1:0];
        ADDR_OUTSEL: next_outsel     = reg_wdata_in[3:0];
        default:     next_cfg        = cfg;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_CTRL:   next_rdata = {24'h000000, cfg};
        ADDR_LEAD:   next_rdata = {16'h0000, lead_time};
        ADDR_SREQ:   next_rdata = {16'h0000, sreq_time};
        ADDR_MEAS:   next_rdata = {16'h0000, meas_time};
        ADDR_CAL:    next_rdata = {16'h0000, cal_time};
        ADDR_CLEAN:  next_rdata = {16'h0000, clean_time};
        ADDR_OUTSEL: next_rdata = {28'h0000000, outsel};
        ADDR_STATUS: next_rdata = {11'h000, trig_act, din_act, ch_status[1], ch_status[0]};
        default:     next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg           <= asq_cfg_t'(CTRL_RST);
      lead_time     <= LEAD_RST;
      sreq_time     <= SREQ_RST;
      meas_time     <= MEAS_RST;
      cal_time      <= CAL_RST;
      clean_time    <= CLEAN_RST;
      outsel        <= OUTSEL_RST;
      reg_rdata_out <= '0;
    end else begin
      cfg           <= next_cfg;
      lead_time     <= next_lead_time;
      sreq_time     <= next_sreq_time;
      meas_time     <= next_meas_time;
      cal_time      <= next_cal_time;
      clean_time    <= next_clean_time;
      outsel        <= next_outsel;
      reg_rdata_out <= next_rdata;
    end
  end

  function automatic asq_kind_t pick_kind(input logic [2:0] due);
    if (due[2]) begin
      return ASQ_K_CLEAN;
    end else if (due[1]) begin
      return ASQ_K_CAL;
    end
    return ASQ_K_MEAS;
  endfunction

  for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
    asq_state_t    st;
    asq_state_t    next_st;
    asq_kind_t     kind;
    asq_kind_t     next_kind;
    logic [TW-1:0] cnt;
    logic [TW-1:0] next_cnt;
    logic [TW-1:0] scnt;
    logic [TW-1:0] next_scnt;
    logic [2:0]    due;
    logic [2:0]    next_due;
    logic [2:0]    set;
    logic [2:0]    clr;
    logic          want;

    always_comb begin
      set = '0;
      if (reg_wr_in && reg_addr_in == ADDR_CMD && (c == 0 || cfg.dual)) begin
        set = reg_wdata_in[c*CMD_STRIDE +: CMD_STRIDE];
      end
      want      = access[c] && (due != 3'h0 || cfg.cont[c]);
      next_st   = st;
      next_kind = kind;
      next_cnt  = cnt;
      next_scnt = (scnt != '0) ? scnt - 16'h0001 : scnt;
      clr       = '0;
      case (st)
        ASQ_IDLE: begin
          if (want) begin
            next_st   = ASQ_LEAD;
            next_kind = pick_kind(due);
            next_cnt  = lead_time;
            next_scnt = (sreq_time == '0) ? 16'h0001 : sreq_time;
          end
        end
        ASQ_LEAD: begin
          if (!access[c]) begin
            next_st   = ASQ_IDLE;
            next_scnt = '0;
          end else if (cnt == '0) begin
            next_st  = ASQ_RUN;
            clr      = kind;
            next_cnt = (kind == ASQ_K_MEAS) ? meas_time : (kind == ASQ_K_CAL) ? cal_time : clean_time;
          end else begin
            next_cnt = cnt - 16'h0001;
          end
        end
        ASQ_RUN: begin
          if (cnt != '0) begin
            next_cnt = cnt - 16'h0001;
          end else if (want) begin
            next_st   = ASQ_LEAD;
            next_kind = pick_kind(due);
            next_cnt  = lead_time;
            next_scnt = (sreq_time == '0) ? 16'h0001 : sreq_time;
          end else begin
            next_st = ASQ_IDLE;
          end
        end
        default: next_st = ASQ_IDLE;
      endcase
      // A command that lands on the clearing cycle stays pending.
      next_due = (due & ~clr) | set;
    end

    always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        st   <= ASQ_IDLE;
        kind <= ASQ_K_MEAS;
        cnt  <= '0;
        scnt <= '0;
        due  <= '0;
      end else begin
        st   <= next_st;
        kind <= next_kind;
        cnt  <= next_cnt;
        scnt <= next_scnt;
        due  <= next_due;
      end
    end

    assign meas_nx[c]   = (next_st == ASQ_RUN) && (next_kind == ASQ_K_MEAS);
    assign sreq_nx[c]   = (next_scnt != '0);
    assign clean_nx[c]  = (next_st == ASQ_RUN) && (next_kind == ASQ_K_CLEAN);
    assign ch_status[c] = {due, kind, st};

    run_gated_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (st == ASQ_LEAD && next_st == ASQ_RUN) |-> access[c])
      else $error("activity started without process access");
    held_off_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (st == ASQ_IDLE && !access[c]) |=> st == ASQ_IDLE)
      else $error("activity left idle while access inactive");
    meas_only_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      meas_active_out[c] |-> (st == ASQ_RUN && kind == ASQ_K_MEAS))
      else $error("measurement active outside a measurement");
    sreq_before_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (st != ASQ_LEAD ##1 st == ASQ_LEAD) |-> sample_req_out[c])
      else $error("sample required missing at activity lead");
    lead_delay_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (st == ASQ_LEAD && next_st == ASQ_RUN) |-> cnt == '0)
      else $error("activity started before lead time elapsed");
    cont_start_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (st == ASQ_IDLE && access[c] && cfg.cont[c] && due == 3'h0) |=> (st == ASQ_LEAD && kind == ASQ_K_MEAS))
      else $error("continuous measurement did not start");
    due_first_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (st == ASQ_IDLE && access[c] && due[2]) |=> (st == ASQ_LEAD && kind == ASQ_K_CLEAN))
      else $error("due cleaning not taken first");
    chain_gap_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
      (st == ASQ_RUN && cnt == '0 && access[c] && cfg.cont[c]) |=> st == ASQ_LEAD)
      else $error("continuous measurement chain broken");
  end

  always_comb begin
    for (int i = 0; i < DOUT_NUM; i++) begin
      // Channel two selections fall back to channel one on a single-channel build.
      if (outsel[2*i+1]) begin
        next_bin[i] = sreq_nx[outsel[2*i] & cfg.dual];
      end else begin
        next_bin[i] = meas_nx[outsel[2*i] & cfg.dual];
      end
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meas_active_out <= '0;
      sample_req_out  <= '0;
      bin_out         <= '0;
      clean_unit_out  <= 1'b0;
      hold_fwd_out    <= 1'b0;
      clean_fwd_out   <= 1'b0;
    end else begin
      meas_active_out <= meas_nx;
      sample_req_out  <= sreq_nx;
      bin_out         <= next_bin;
      clean_unit_out  <= trig_act | (|clean_nx);
      hold_fwd_out    <= trig_act | (|clean_nx);
      clean_fwd_out   <= trig_act;
    end
  end

  trig_fwd_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
    trig_act |=> (clean_unit_out && hold_fwd_out && clean_fwd_out))
    else $error("cleaning trigger not forwarded");
endmodule

//--- testbench/asq_plc_model.sv
/*
  Model of the external controller that drives the process-access pins
  and the cleaning trigger pin of the sequencer.
  Assumes the bench changes its requests just after a rising clock edge.
*/
`timescale 1ns/1ps
module asq_plc_model
  import asq_pkg::*;
(
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               arst_n_in,
  // Bench requests
  input  wire logic [DIN_NUM-1:0] acc_req_in,
  input  wire logic [DIN_NUM-1:0] pol_in,
  input  wire logic               trig_req_in,
  input  wire logic               one_shot_in,
  // Device status
  input  wire logic               meas_in,
  // Pins
  output logic      [DIN_NUM-1:0] pin_out,
  output logic                    trig_out
);
  logic               stop;
  logic [DIN_NUM-1:0] act;

  // Access is taken away while the single wanted measurement still runs.
  assign act = stop ? '0 : acc_req_in;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stop     <= 1'b0;
      pin_out  <= ~pol_in;
      trig_out <= 1'b0;
    end else begin
      stop     <= one_shot_in && (stop || meas_in);
      pin_out  <= ~(act ^ pol_in);
      trig_out <= trig_req_in;
    end
  end
endmodule

//--- testbench/testbench.sv
/*
  Self-checking bench of the sequencer: register access, activity order,
  lead and request times, polarity, channel choice and cleaning master.
  Assumes a 100 MHz clock and the controller model on the binary pins.
*/
`timescale 1ns/1ps
module testbench;
  import asq_pkg::*;
  logic                clock_in  = 1'b0;
  logic                arst_n_in = 1'b0;
  logic [AW-1:0]       addr      = '0;
  logic [DW-1:0]       wdata     = '0;
  logic                wr_s      = 1'b0;
  logic                rd_s      = 1'b0;
  logic [DW-1:0]       rdata;
  logic [DIN_NUM-1:0]  pins;
  logic                trig;
  logic [CH_NUM-1:0]   ma;
  logic [CH_NUM-1:0]   sr;
  logic [DOUT_NUM-1:0] bo;
  logic                cu;
  logic                hf;
  logic                cf;
  logic [DIN_NUM-1:0]  acc       = '0;
  logic [DIN_NUM-1:0]  pol       = 2'h3;
  logic                trigq     = 1'b0;
  logic                one       = 1'b0;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int n_ma, n_sr, n_bo, n_b1, n_cu, n_hf, n_cf, n_rise, t_sr, t_ma, t2;
  logic p_ma, p_sr;

  always #5 clock_in = ~clock_in;

  asq_sequencer dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .bin_in(pins), .clean_trig_in(trig), .meas_active_out(ma), .sample_req_out(sr),
    .bin_out(bo), .clean_unit_out(cu), .hold_fwd_out(hf), .clean_fwd_out(cf));

  asq_plc_model plc (.clock_in(clock_in), .arst_n_in(arst_n_in), .acc_req_in(acc),
    .pol_in(pol), .trig_req_in(trigq), .one_shot_in(one), .meas_in(ma[0]),
    .pin_out(pins), .trig_out(trig));

  task automatic give_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clock_in);
    wr_s  <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_in);
    rd_s <= 1'b0;
    #1;
    chk_reg(rdata, e);
  endtask

  task automatic clr();
    n_ma   = 0;
    n_sr   = 0;
    n_bo   = 0;
    n_b1   = 0;
    n_cu   = 0;
    n_hf   = 0;
    n_cf   = 0;
    n_rise = 0;
    t_sr   = -1;
    t_ma   = -1;
    t2     = -1;
    p_ma   = 1'b0;
    p_sr   = 1'b0;
  endtask

  // Counts high cycles and first rises of one channel over n cycles.
  task automatic watch(input int n, input int ch);
    repeat (n) begin
      @(posedge clock_in);
      #1;
      cyc++;
      if (sr[ch] === 1'b1 && !p_sr && t_sr < 0) t_sr = cyc;
      if (ma[ch] === 1'b1 && !p_ma) begin
        n_rise++;
        if (t_ma < 0) t_ma = cyc;
        else if (t2 < 0) t2 = cyc;
      end
      p_sr = (sr[ch] === 1'b1);
      p_ma = (ma[ch] === 1'b1);
      n_sr += p_sr;
      n_ma += p_ma;
      n_bo += (bo[0] === 1'b1);
      n_b1 += (bo[1] === 1'b1);
      n_cu += (cu === 1'b1);
      n_hf += (hf === 1'b1);
      n_cf += (cf === 1'b1);
    end
  endtask

  // A hang would stall every bounded window below; cut the run here instead.
  initial begin
    #500000;
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
    #1;
    rd(ADDR_CTRL, 32'h000000D9);
    rd(ADDR_LEAD, {16'h0000, LEAD_RST});
    rd(ADDR_OUTSEL, {28'h0000000, OUTSEL_RST});
    rd(ADDR_CMD, 32'h00000000);
    rd(4'hF, 32'h00000000);
    rd(ADDR_STATUS, 32'h00001209);
    wr(ADDR_LEAD, 32'h00000002);
    wr(ADDR_SREQ, 32'h00000004);
    wr(ADDR_MEAS, 32'h00000007);
    wr(ADDR_CAL, 32'h00000002);
    wr(ADDR_CLEAN, 32'h00000002);
    rd(ADDR_MEAS, 32'h00000007);
    wr(ADDR_CMD, 32'h00000001);
    clr();
    watch(20, 0);
    chk_cnt(n_sr + n_ma, 0);
    rd(ADDR_STATUS, 32'h00001249);
    acc <= 2'h1;
    clr();
    watch(30, 0);
    chk_cnt(n_ma, 8);
    chk_cnt(n_sr, 4);
    chk_cnt(t_ma - t_sr, 3);
    chk_cnt(n_bo, 8);
    chk_cnt(n_b1, 4);
    clr();
    wr(ADDR_CMD, 32'h00000002);
    watch(20, 0);
    chk_cnt(n_ma, 0);
    chk_cnt(n_sr, 4);
    clr();
    wr(ADDR_CMD, 32'h00000004);
    watch(20, 0);
    chk_cnt(n_ma, 0);
    chk_cnt(n_cu, 3);
    chk_cnt(n_hf, 3);
    chk_cnt(n_cf, 0);
    acc <= 2'h0;
    watch(10, 0);
    clr();
    trigq <= 1'b1;
    watch(20, 0);
    trigq <= 1'b0;
    watch(20, 0);
    chk_cnt(n_cu, 20);
    chk_cnt(n_hf, 20);
    chk_cnt(n_cf, 20);
    wr(ADDR_CTRL, 32'h000000DB);
    one <= 1'b1;
    wr(ADDR_CMD, 32'h00000002);
    clr();
    acc <= 2'h1;
    watch(40, 0);
    chk_cnt(t_ma - t_sr, 9);
    chk_cnt(n_rise, 1);
    chk_cnt(n_ma, 8);
    one <= 1'b0;
    acc <= 2'h0;
    watch(5, 0);
    clr();
    acc <= 2'h1;
    watch(40, 0);
    chk_cnt(t2 - t_ma, 11);
    acc <= 2'h0;
    wr(ADDR_CTRL, 32'h000000D9);
    watch(20, 0);
    pol <= 2'h2;
    wr(ADDR_CTRL, 32'h000000D1);
    watch(5, 0);
    wr(ADDR_CMD, 32'h00000001);
    clr();
    acc <= 2'h1;
    watch(30, 0);
    chk_cnt(n_ma, 8);
    acc <= 2'h0;
    pol <= 2'h3;
    wr(ADDR_CTRL, 32'h000000D9);
    watch(5, 0);
    wr(ADDR_OUTSEL, 32'h0000000D);
    clr();
    acc <= 2'h2;
    wr(ADDR_CMD, 32'h00000008);
    watch(30, 1);
    chk_cnt(n_ma, 8);
    chk_cnt(n_bo, 8);
    chk_cnt(n_b1, 4);
    wr(ADDR_CTRL, 32'h000000D8);
    acc <= 2'h3;
    wr(ADDR_CMD, 32'h00000009);
    clr();
    watch(30, 1);
    chk_cnt(n_ma, 0);
    chk_cnt(n_sr, 0);
    chk_cnt(n_bo, 8);
    chk_cnt(n_b1, 4);
    give_verdict();
  end
endmodule
